//--- pkg/oag_consts.svh
`ifndef OAG_CONSTS_SVH
`define OAG_CONSTS_SVH

// First fetch address after reset
`define OAG_RESET_PC     16'h0100

// Accumulator load opcodes and the multiply opcode
`define OAG_OP_LDA_IMM   8'hA6
`define OAG_OP_LDA_DIR   8'hB6
`define OAG_OP_LDA_EXT   8'hC6
`define OAG_OP_MUL       8'h42

// Opcode rows (high nibble)
`define OAG_ROW_BITBR    4'h0
`define OAG_ROW_BITSC    4'h1
`define OAG_ROW_REL      4'h2
`define OAG_ROW_RMW_DIR  4'h3
`define OAG_ROW_INH_A    4'h4
`define OAG_ROW_INH_X    4'h5
`define OAG_ROW_RMW_IX1  4'h6
`define OAG_ROW_RMW_IX   4'h7
`define OAG_ROW_SYS      4'h8
`define OAG_ROW_XFER     4'h9
`define OAG_ROW_IMM      4'hA
`define OAG_ROW_DIR      4'hB
`define OAG_ROW_EXT      4'hC
`define OAG_ROW_IX2      4'hD
`define OAG_ROW_IX1      4'hE

// Register-memory functions (low nibble)
`define OAG_FN_SUB       4'h0
`define OAG_FN_CMP       4'h1
`define OAG_FN_SBC       4'h2
`define OAG_FN_CPX       4'h3
`define OAG_FN_AND       4'h4
`define OAG_FN_BIT       4'h5
`define OAG_FN_LDA       4'h6
`define OAG_FN_STA       4'h7
`define OAG_FN_EOR       4'h8
`define OAG_FN_ADC       4'h9
`define OAG_FN_ORA       4'hA
`define OAG_FN_ADD       4'hB
`define OAG_FN_JMP       4'hC
`define OAG_FN_JSR       4'hD
`define OAG_FN_LDX       4'hE
`define OAG_FN_STX       4'hF

// Single-operand functions (low nibble)
`define OAG_UN_NEG       4'h0
`define OAG_UN_COM       4'h3
`define OAG_UN_LSR       4'h4
`define OAG_UN_ROR       4'h6
`define OAG_UN_ASR       4'h7
`define OAG_UN_LSL       4'h8
`define OAG_UN_ROL       4'h9
`define OAG_UN_DEC       4'hA
`define OAG_UN_INC       4'hC
`define OAG_UN_CLR       4'hF

// Transfer and flag row functions
`define OAG_XF_TAX       4'h7
`define OAG_XF_CLC       4'h8
`define OAG_XF_SEC       4'h9
`define OAG_XF_CLI       4'hA
`define OAG_XF_SEI       4'hB
`define OAG_XF_TXA       4'hF

// Legal low nibbles per row, one bit each
`define OAG_UN_MASK      16'hB7D9
`define OAG_SYS_MASK     16'hC00B
`define OAG_XFER_MASK    16'hBF80

// Condition code bits and reset value
`define OAG_CC_C         0
`define OAG_CC_Z         1
`define OAG_CC_N         2
`define OAG_CC_I         3
`define OAG_CCR_RESET    5'h08

`endif

//--- pkg/oag_pkg.sv
package oag_pkg;

  typedef enum logic [2:0] {
    M_INH = 3'h0,
    M_IMM = 3'h1,
    M_DIR = 3'h2,
    M_EXT = 3'h3,
    M_IX  = 3'h4,
    M_IX1 = 3'h5,
    M_IX2 = 3'h6,
    M_REL = 3'h7
  } oag_mode_t;

  typedef enum logic [2:0] {
    C_REG, C_XFER, C_ALU, C_LOAD, C_STORE, C_JMP, C_RMW, C_OTHER
  } oag_class_t;

  typedef enum logic [2:0] {
    S_START = 3'h0,
    S_OPC   = 3'h1,
    S_B1    = 3'h3,
    S_B2    = 3'h2,
    S_MEM   = 3'h6
  } oag_state_t;

endpackage

//--- hw/oag_decode.sv
`timescale 1ns/1ps
`include "oag_consts.svh"
module oag_decode
  import oag_pkg::*;
(
  // Opcode byte
  input  wire logic [7:0] opcode,
  // Decode results
  output oag_mode_t       mode,
  output logic [1:0]      len,
  output oag_class_t      cls,
  output logic            to_x,
  output logic            legal
);

  wire        [3:0]  hi     = opcode[7:4];
  wire        [3:0]  lo     = opcode[3:0];
  wire        [15:0] un_msk = `OAG_UN_MASK;
  wire        [15:0] sy_msk = `OAG_SYS_MASK;
  wire        [15:0] xf_msk = `OAG_XFER_MASK;
  wire               un_ok  = un_msk[lo];
  wire               is_lda = (opcode == `OAG_OP_LDA_IMM) ||
                              (opcode == `OAG_OP_LDA_DIR) ||
                              (opcode == `OAG_OP_LDA_EXT);
  wire               is_ld  = is_lda || (lo == `OAG_FN_LDA) ||
                              (lo == `OAG_FN_LDX);
  wire               is_st  = (lo == `OAG_FN_STA) ||
                              (lo == `OAG_FN_STX);
  wire               is_jmp = (lo == `OAG_FN_JMP);
  wire               is_jsr = (lo == `OAG_FN_JSR);
  wire               bin_rw = (hi >= `OAG_ROW_IMM);
  oag_class_t        bin_cl;

  assign bin_cl = is_st  ? C_STORE :
                  is_jmp ? C_JMP   :
                  is_jsr ? C_OTHER :
                  is_ld  ? C_LOAD  : C_ALU;

  // Pointer forms of register ops
  assign to_x = bin_rw ? ((lo == `OAG_FN_CPX) || (lo == `OAG_FN_LDX) ||
                          (lo == `OAG_FN_STX))
                       : (hi == `OAG_ROW_INH_X);

  // Mode and length from the opcode alone
  always_comb begin
    mode  = M_INH;
    len   = 2'h1;
    cls   = C_OTHER;
    legal = 1'h1;
    case (hi)
      `OAG_ROW_BITBR: begin
        mode = M_DIR;
        len  = 2'h3;
      end
      `OAG_ROW_BITSC: begin
        mode = M_DIR;
        len  = 2'h2;
      end
      `OAG_ROW_REL: begin
        mode = M_REL;
        len  = 2'h2;
      end
      `OAG_ROW_RMW_DIR: begin
        mode  = M_DIR;
        len   = 2'h2;
        cls   = C_RMW;
        legal = un_ok;
      end
      `OAG_ROW_INH_A, `OAG_ROW_INH_X: begin
        cls   = un_ok ? C_REG : C_OTHER;
        legal = un_ok || (opcode == `OAG_OP_MUL);
      end
      `OAG_ROW_RMW_IX1: begin
        mode  = M_IX1;
        len   = 2'h2;
        cls   = C_RMW;
        legal = un_ok;
      end
      `OAG_ROW_RMW_IX: begin
        mode  = M_IX;
        cls   = C_RMW;
        legal = un_ok;
      end
      `OAG_ROW_SYS: legal = sy_msk[lo];
      `OAG_ROW_XFER: begin
        cls   = C_XFER;
        legal = xf_msk[lo];
      end
      `OAG_ROW_IMM: begin
        mode  = M_IMM;
        len   = 2'h2;
        cls   = bin_cl;
        legal = !(is_st || is_jmp || is_jsr);
      end
      `OAG_ROW_DIR: begin
        mode = M_DIR;
        len  = 2'h2;
        cls  = bin_cl;
      end
      `OAG_ROW_EXT: begin
        mode = M_EXT;
        len  = 2'h3;
        cls  = bin_cl;
      end
      `OAG_ROW_IX2: begin
        mode = M_IX2;
        len  = 2'h3;
        cls  = bin_cl;
      end
      `OAG_ROW_IX1: begin
        mode = M_IX1;
        len  = 2'h2;
        cls  = bin_cl;
      end
      default: begin
        mode = M_IX;
        cls  = bin_cl;
      end
    endcase
  end

endmodule

//--- hw/oag_top.sv
// How it works
// - Inherent opcodes are one byte and fetch no operand
// - Inherent register ops act on accumulator or pointer, per opcode form
// - Accumulator increment adds one, writes back, updates flags
// - Immediate operand is the byte after the opcode; two bytes total
// - Immediate mode only for arithmetic, logic, compare, bit test, loads
// - Extended address is high byte first, then low byte, concatenated
// - Extended instructions are three bytes and reach the whole space
// - Extended serves arithmetic, logic, compare, load, store, jumps; no RMW (here JSR retires without jumping, only JMP jumps)
// - Accumulator load opcodes are A6, B6 and C6 for imm, dir, ext
// - Direct address is the operand byte with high byte forced zero
// - Direct instructions are normally two bytes
// - Direct mode serves ALU, load, store, jump, RMW and bit ops (here bit ops and JSR retire with no effect)
// - Inherent set holds flag, transfer, stack, return, system ops
// - Indexed address is pointer plus offset: none, 8-bit or 16-bit
// - No-offset indexed address is the pointer alone; one byte
// - 8-bit offset indexed adds unsigned byte to pointer; two bytes
// - 16-bit offset indexed adds two-byte offset to pointer; three bytes
// - Indexed address forming never changes the pointer register
`timescale 1ns/1ps
`include "oag_consts.svh"
module oag_top
  import oag_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  // Memory bus, read data valid while MEM_RD stands
  output logic      [15:0] MEM_ADDR,
  output logic             MEM_RD,
  output logic             MEM_WR,
  output logic      [7:0]  MEM_WDATA,
  input  wire logic [7:0]  MEM_RDATA,
  // Programmer registers
  output logic      [7:0]  ACC,
  output logic      [7:0]  IDX,
  output logic      [4:0]  CCR,
  // Decode status
  output logic      [15:0] OPERAND_LOCATION,
  output logic             LOC_VALID,
  output oag_mode_t        MODE,
  output logic      [1:0]  INSTR_LEN,
  output logic             ILLEGAL,
  output logic             INSTR_DONE
);

  oag_state_t        state_q, state_d;
  logic       [15:0] pc_q, pc_d;
  logic       [7:0]  opc_q, opc_d;
  logic       [7:0]  b1_q, b1_d;
  logic       [15:0] loc_q, loc_d;
  logic       [7:0]  acc_q, acc_d;
  logic       [7:0]  idx_q, idx_d;
  logic       [4:0]  ccr_q, ccr_d;
  logic       [15:0] addr_q, addr_d;
  logic              rd_q, rd_d;
  logic              wr_q, wr_d;
  logic       [7:0]  wdata_q, wdata_d;
  logic              lv_q, lv_d;
  oag_mode_t         mode_q, mode_d;
  logic       [1:0]  len_q, len_d;
  logic              ill_q, ill_d;
  logic              done_q, done_d;

  // Decoder sees the fresh opcode while it is on the bus
  wire        [7:0]  opc_w = (state_q == S_OPC) ? MEM_RDATA : opc_q;
  oag_mode_t         dec_mode;
  logic       [1:0]  dec_len;
  oag_class_t        dec_cls;
  logic              dec_tox;
  logic              dec_legal;

  oag_decode u_dec (
    .opcode (opc_w),
    .mode   (dec_mode),
    .len    (dec_len),
    .cls    (dec_cls),
    .to_x   (dec_tox),
    .legal  (dec_legal)
  );

  wire        [3:0]  fn     = opc_w[3:0];
  wire               c_in   = ccr_q[`OAG_CC_C];
  wire        [7:0]  src    = dec_tox ? idx_q : acc_q;
  wire        [7:0]  un_src = (state_q == S_MEM) ? MEM_RDATA : src;
  wire               no_wb  = (fn == `OAG_FN_CMP) ||
                              (fn == `OAG_FN_CPX) ||
                              (fn == `OAG_FN_BIT);

  function automatic logic [8:0] alu_un(
    input logic [3:0] f,
    input logic [7:0] v,
    input logic       c
  );
    case (f)
      `OAG_UN_NEG: alu_un = {v != 8'h00, 8'h00 - v};
      `OAG_UN_COM: alu_un = {1'h1, ~v};
      `OAG_UN_LSR: alu_un = {v[0], 1'h0, v[7:1]};
      `OAG_UN_ROR: alu_un = {v[0], c, v[7:1]};
      `OAG_UN_ASR: alu_un = {v[0], v[7], v[7:1]};
      `OAG_UN_LSL: alu_un = {v[7], v[6:0], 1'h0};
      `OAG_UN_ROL: alu_un = {v[7], v[6:0], c};
      `OAG_UN_DEC: alu_un = {c, v - 8'h01};
      `OAG_UN_INC: alu_un = {c, v + 8'h01};
      `OAG_UN_CLR: alu_un = {c, 8'h00};
      default:     alu_un = {c, v};
    endcase
  endfunction

  function automatic logic [8:0] alu_bin(
    input logic [3:0] f,
    input logic [7:0] a,
    input logic [7:0] m,
    input logic       c
  );
    case (f)
      `OAG_FN_SUB, `OAG_FN_CMP, `OAG_FN_CPX:
        alu_bin = {1'h0, a} - {1'h0, m};
      `OAG_FN_SBC: alu_bin = {1'h0, a} - {1'h0, m} - {8'h00, c};
      `OAG_FN_ADD: alu_bin = {1'h0, a} + {1'h0, m};
      `OAG_FN_ADC: alu_bin = {1'h0, a} + {1'h0, m} + {8'h00, c};
      `OAG_FN_AND, `OAG_FN_BIT: alu_bin = {c, a & m};
      `OAG_FN_ORA: alu_bin = {c, a | m};
      `OAG_FN_EOR: alu_bin = {c, a ^ m};
      default:     alu_bin = {c, m};
    endcase
  endfunction

  // Effective address; pointer is only read here
  function automatic logic [15:0] loc_of(
    input oag_mode_t  m,
    input logic [7:0] hb,
    input logic [7:0] lb,
    input logic [7:0] x
  );
    case (m)
      M_DIR:   loc_of = {8'h00, lb};
      M_EXT:   loc_of = {hb, lb};
      M_IX:    loc_of = {8'h00, x};
      M_IX1:   loc_of = {8'h00, lb} + {8'h00, x};
      M_IX2:   loc_of = {hb, lb} + {8'h00, x};
      default: loc_of = {hb, lb};
    endcase
  endfunction

  function automatic logic [4:0] flags(
    input logic [4:0] cc,
    input logic [8:0] r
  );
    logic [4:0] t;
    t = cc;
    t[`OAG_CC_C] = r[8];
    t[`OAG_CC_Z] = (r[7:0] == 8'h00);
    t[`OAG_CC_N] = r[7];
    flags = t;
  endfunction

  // Binary ALU result from the byte on the bus; unary result from it only in S_MEM, else from the register
  wire        [8:0]  res_b = alu_bin(fn, src, MEM_RDATA, c_in);
  wire        [8:0]  res_u = alu_un(fn, un_src, c_in);

  logic              go_mem;
  logic       [15:0] loc_n;
  logic              fetch;

  always_comb begin
    state_d = state_q;
    pc_d    = pc_q;
    opc_d   = opc_q;
    b1_d    = b1_q;
    loc_d   = loc_q;
    acc_d   = acc_q;
    idx_d   = idx_q;
    ccr_d   = ccr_q;
    addr_d  = addr_q;
    rd_d    = 1'h0;
    wr_d    = 1'h0;
    wdata_d = wdata_q;
    lv_d    = 1'h0;
    mode_d  = mode_q;
    len_d   = len_q;
    ill_d   = 1'h0;
    done_d  = 1'h0;
    go_mem  = 1'h0;
    loc_n   = loc_q;
    fetch   = 1'h0;
    case (state_q)
      S_START: begin
        rd_d    = 1'h1;
        addr_d  = pc_q;
        pc_d    = pc_q + 16'h0001;
        state_d = S_OPC;
      end
      S_OPC: begin
        opc_d  = MEM_RDATA;
        mode_d = dec_mode;
        len_d  = dec_len;
        if (!dec_legal) begin
          // Unknown opcode retires as one byte
          ill_d   = 1'h1;
          done_d  = 1'h1;
          state_d = S_START;
        end else if (dec_len != 2'h1) begin
          fetch = 1'h1;
        end else if (dec_mode == M_IX) begin
          go_mem = 1'h1;
          loc_n  = loc_of(M_IX, 8'h00, 8'h00, idx_q);
        end else begin
          // Inherent: no operand bytes at all
          done_d  = 1'h1;
          state_d = S_START;
          if (dec_cls == C_REG) begin
            ccr_d = flags(ccr_q, res_u);
            if (dec_tox) begin
              idx_d = res_u[7:0];
            end else begin
              acc_d = res_u[7:0];
            end
          end else if (dec_cls == C_XFER) begin
            case (fn)
              `OAG_XF_TAX: idx_d = acc_q;
              `OAG_XF_TXA: acc_d = idx_q;
              `OAG_XF_CLC: ccr_d[`OAG_CC_C] = 1'h0;
              `OAG_XF_SEC: ccr_d[`OAG_CC_C] = 1'h1;
              `OAG_XF_CLI: ccr_d[`OAG_CC_I] = 1'h0;
              `OAG_XF_SEI: ccr_d[`OAG_CC_I] = 1'h1;
              default:     ccr_d = ccr_q;
            endcase
          end
        end
      end
      S_B1: begin
        b1_d = MEM_RDATA;
        if (len_q == 2'h3) begin
          fetch = 1'h1;
        end else if (dec_mode == M_IMM) begin
          // Operand is the fetched byte itself
          done_d = 1'h1;
          state_d = S_START;
          ccr_d = flags(ccr_q, res_b);
          if (!no_wb) begin
            if (dec_tox) begin
              idx_d = res_b[7:0];
            end else begin
              acc_d = res_b[7:0];
            end
          end
        end else if (dec_cls == C_OTHER) begin
          done_d  = 1'h1;
          state_d = S_START;
        end else begin
          go_mem = 1'h1;
          loc_n  = loc_of(dec_mode, 8'h00, MEM_RDATA, idx_q);
        end
      end
      S_B2: begin
        if (dec_cls == C_OTHER) begin
          done_d  = 1'h1;
          state_d = S_START;
        end else begin
          go_mem = 1'h1;
          loc_n  = loc_of(dec_mode, b1_q, MEM_RDATA, idx_q);
        end
      end
      S_MEM: begin
        done_d  = 1'h1;
        state_d = S_START;
        if (dec_cls == C_RMW) begin
          ccr_d   = flags(ccr_q, res_u);
          wr_d    = 1'h1;
          wdata_d = res_u[7:0];
        end else begin
          ccr_d = flags(ccr_q, res_b);
          if (!no_wb) begin
            if (dec_tox) begin
              idx_d = res_b[7:0];
            end else begin
              acc_d = res_b[7:0];
            end
          end
        end
      end
      default: state_d = S_START;
    endcase
    // Next program byte
    if (fetch) begin
      rd_d    = 1'h1;
      addr_d  = pc_q;
      pc_d    = pc_q + 16'h0001;
      state_d = (state_q == S_OPC) ? S_B1 : S_B2;
    end
    // Data access at the operand location
    if (go_mem) begin
      loc_d  = loc_n;
      lv_d   = 1'h1;
      addr_d = loc_n;
      case (dec_cls)
        C_STORE: begin
          wr_d    = 1'h1;
          wdata_d = src;
          done_d  = 1'h1;
          state_d = S_START;
        end
        C_JMP: begin
          // Jump reuses the operand location as target
          pc_d    = loc_n;
          done_d  = 1'h1;
          state_d = S_START;
        end
        default: begin
          rd_d    = 1'h1;
          state_d = S_MEM;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      state_q <= S_START;
      pc_q    <= `OAG_RESET_PC;
      opc_q   <= 8'h00;
      b1_q    <= 8'h00;
      loc_q   <= 16'h0000;
      acc_q   <= 8'h00;
      idx_q   <= 8'h00;
      ccr_q   <= `OAG_CCR_RESET;
    end else begin
      state_q <= state_d;
      pc_q    <= pc_d;
      opc_q   <= opc_d;
      b1_q    <= b1_d;
      loc_q   <= loc_d;
      acc_q   <= acc_d;
      idx_q   <= idx_d;
      ccr_q   <= ccr_d;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      addr_q  <= 16'h0000;
      rd_q    <= 1'h0;
      wr_q    <= 1'h0;
      wdata_q <= 8'h00;
      lv_q    <= 1'h0;
      mode_q  <= M_INH;
      len_q   <= 2'h1;
      ill_q   <= 1'h0;
      done_q  <= 1'h0;
    end else begin
      addr_q  <= addr_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      wdata_q <= wdata_d;
      lv_q    <= lv_d;
      mode_q  <= mode_d;
      len_q   <= len_d;
      ill_q   <= ill_d;
      done_q  <= done_d;
    end
  end

  assign MEM_ADDR         = addr_q;
  assign MEM_RD           = rd_q;
  assign MEM_WR           = wr_q;
  assign MEM_WDATA        = wdata_q;
  assign ACC              = acc_q;
  assign IDX              = idx_q;
  assign CCR              = ccr_q;
  assign OPERAND_LOCATION = loc_q;
  assign LOC_VALID        = lv_q;
  assign MODE             = mode_q;
  assign INSTR_LEN        = len_q;
  assign ILLEGAL          = ill_q;
  assign INSTR_DONE       = done_q;

endmodule

//--- verification/oag_top_chk.sv
`timescale 1ns/1ps
module oag_chk
  import oag_pkg::*;
(
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RST_B,
  // Memory bus
  input wire logic [15:0] MEM_ADDR,
  input wire logic        MEM_RD,
  input wire logic        MEM_WR,
  // Pointer and decode status
  input wire logic [7:0]  IDX,
  input wire logic [15:0] OPERAND_LOCATION,
  input wire logic        LOC_VALID,
  input wire oag_mode_t   MODE,
  input wire logic [1:0]  INSTR_LEN,
  input wire logic        ILLEGAL,
  input wire logic        INSTR_DONE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  // Write retires the instruction, bus goes straight back to fetch
  sequence s_store_retire;
    MEM_WR && INSTR_DONE;
  endsequence
  sequence s_fetch;
    MEM_RD && !MEM_WR;
  endsequence
  sequence s_inh_retire;
    INSTR_DONE && (MODE == M_INH) && !ILLEGAL;
  endsequence

  chk_wr_then_fetch: assert property (
    MEM_WR |-> s_store_retire ##1 s_fetch)
    else $error("write not followed by retire and fetch");
  chk_retire_fetch: assert property (
    INSTR_DONE && !MEM_WR |=> MEM_RD)
    else $error("no opcode fetch after retire");
  chk_illegal_retire: assert property (
    ILLEGAL |-> INSTR_DONE)
    else $error("refused opcode not retired");
  chk_dir_page: assert property (
    LOC_VALID && MODE == M_DIR |-> OPERAND_LOCATION[15:8] == 8'h00)
    else $error("direct location left page zero");
  chk_ix_plain: assert property (
    LOC_VALID && MODE == M_IX |-> OPERAND_LOCATION == {8'h00, IDX})
    else $error("plain indexed location not the pointer");
  chk_loc_on_bus: assert property (
    LOC_VALID && (MEM_RD || MEM_WR) |-> MEM_ADDR == OPERAND_LOCATION)
    else $error("bus address differs from location");
  chk_ix_keeps: assert property (
    LOC_VALID && MODE inside {M_IX, M_IX1, M_IX2} |-> $stable(IDX))
    else $error("pointer changed while forming location");
  chk_ext_len: assert property (
    MODE == M_EXT |-> INSTR_LEN == 2'h3)
    else $error("extended length not three");
  chk_ix_len: assert property (
    MODE == M_IX |-> INSTR_LEN == 2'h1)
    else $error("plain indexed length not one");
  chk_inh_nofetch: assert property (
    s_inh_retire |-> $past(MEM_RD) && !$past(MEM_RD, 2))
    else $error("inherent opcode fetched an operand");
endmodule

bind oag_top oag_chk u_chk (
  .CLOCK            (CLOCK),
  .RST_B            (RST_B),
  .MEM_ADDR         (MEM_ADDR),
  .MEM_RD           (MEM_RD),
  .MEM_WR           (MEM_WR),
  .IDX              (IDX),
  .OPERAND_LOCATION (OPERAND_LOCATION),
  .LOC_VALID        (LOC_VALID),
  .MODE             (MODE),
  .INSTR_LEN        (INSTR_LEN),
  .ILLEGAL          (ILLEGAL),
  .INSTR_DONE       (INSTR_DONE)
);

//--- verification/oag_mem_model.sv
`timescale 1ns/1ps
module oag_mem_model (
  // Clock
  input  wire logic        CLOCK,
  // Bus from the block
  input  wire logic [15:0] MEM_ADDR,
  input  wire logic        MEM_RD,
  input  wire logic        MEM_WR,
  input  wire logic [7:0]  MEM_WDATA,
  // Read data back
  output logic      [7:0]  MEM_RDATA
);
  logic [7:0] mem [0:65535];

  task automatic fill(input logic [7:0] v);
    for (int i = 0; i < 65536; i++) mem[i] = v;
  endtask

  task automatic put(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask

  // Writes land on the edge that ends the strobe cycle
  always @(posedge CLOCK) begin
    if (MEM_WR) mem[MEM_ADDR] <= MEM_WDATA;
  end

  // Core samples read data while its strobe stands, so settle it mid-cycle
  always @(negedge CLOCK) begin
    // Idle bus shows the inverse so stale data never looks valid
    if (MEM_RD) MEM_RDATA <= mem[MEM_ADDR];
    else MEM_RDATA <= ~mem[MEM_ADDR];
  end
endmodule

//--- verification/oag_top_tb.sv
`timescale 1ns/1ps
module oag_top_tb;
  import oag_pkg::*;
  logic        clock;
  logic        rst_b;
  logic [15:0] mem_addr;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic [7:0]  acc;
  logic [7:0]  idx;
  logic [4:0]  ccr;
  logic [15:0] loc;
  logic        loc_valid;
  oag_mode_t   mode;
  logic [1:0]  instr_len;
  logic        illegal;
  logic        instr_done;
  int          n_fail;
  int          tests_run;
  int          nd;
  logic [15:0] loc_q;
  oag_mode_t   md [8];
  logic [1:0]  ln [8];
  logic [7:0]  ac [8];
  logic [7:0]  ix [8];
  logic [4:0]  cc [8];
  logic [15:0] lc [8];
  logic        il [8];

  oag_top dut (
    .CLOCK            (clock),
    .RST_B            (rst_b),
    .MEM_ADDR         (mem_addr),
    .MEM_RD           (mem_rd),
    .MEM_WR           (mem_wr),
    .MEM_WDATA        (mem_wdata),
    .MEM_RDATA        (mem_rdata),
    .ACC              (acc),
    .IDX              (idx),
    .CCR              (ccr),
    .OPERAND_LOCATION (loc),
    .LOC_VALID        (loc_valid),
    .MODE             (mode),
    .INSTR_LEN        (instr_len),
    .ILLEGAL          (illegal),
    .INSTR_DONE       (instr_done)
  );

  oag_mem_model u_mem (
    .CLOCK     (clock),
    .MEM_ADDR  (mem_addr),
    .MEM_RD    (mem_rd),
    .MEM_WR    (mem_wr),
    .MEM_WDATA (mem_wdata),
    .MEM_RDATA (mem_rdata)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Snapshot of the block at each of the first 8 retires
  always @(posedge clock) begin
    if (rst_b && loc_valid) loc_q = loc;
    if (rst_b && instr_done && nd < 8) begin
      md[nd] = mode;
      ln[nd] = instr_len;
      ac[nd] = acc;
      ix[nd] = idx;
      cc[nd] = ccr;
      lc[nd] = loc_q;
      il[nd] = illegal;
      nd++;
    end
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Filler is a no-operation so the core runs on harmlessly
  task automatic start;
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (16) @(posedge clock);
    u_mem.fill(8'h9D);
    nd = 0;
    loc_q = 16'h0000;
  endtask

  task automatic load(input logic [15:0] a, input logic [7:0] b [$]);
    foreach (b[i]) u_mem.put(a + 16'(i), b[i]);
  endtask

  task automatic run(input int n);
    rst_b <= 1'b1;
    for (int k = 0; k < 300 && nd < n; k++) @(negedge clock);
    if (nd < n) begin
      n_fail++;
      $display("[FAIL] %0t retire count not reached", $time);
      tally_and_finish();
    end
  endtask

  task automatic done_is(input int i, input oag_mode_t m,
                         input logic [1:0] l, input logic [7:0] a);
    check(md[i], m, "mode");
    check(ln[i], l, "length");
    check(ac[i], a, "accumulator");
  endtask

  task automatic t_load_modes;
    start();
    check(acc, 8'h00, "reset acc");
    check(ccr, 5'h08, "reset flags");
    check(mode, M_INH, "reset mode");
    check(instr_len, 2'h1, "reset len");
    load(16'h0100, '{8'hA6, 8'h5A, 8'hB6, 8'h50, 8'hC6, 8'hF1, 8'h23});
    u_mem.put(16'h0050, 8'h3C);
    u_mem.put(16'hF123, 8'hC3);
    run(3);
    done_is(0, M_IMM, 2'h2, 8'h5A);
    done_is(1, M_DIR, 2'h2, 8'h3C);
    check(lc[1], 16'h0050, "direct location");
    done_is(2, M_EXT, 2'h3, 8'hC3);
    check(lc[2], 16'hF123, "extended location");
  endtask

  task automatic t_indexed;
    start();
    load(16'h0100, '{8'hAE, 8'h30, 8'hF6, 8'hE6, 8'h05, 8'hD6, 8'h07,
                     8'h00, 8'hE6, 8'hFF});
    u_mem.put(16'h0030, 8'h11);
    u_mem.put(16'h0035, 8'h22);
    u_mem.put(16'h0730, 8'h33);
    u_mem.put(16'h012F, 8'h44);
    run(5);
    done_is(1, M_IX, 2'h1, 8'h11);
    check(lc[1], 16'h0030, "plain index");
    done_is(2, M_IX1, 2'h2, 8'h22);
    check(lc[2], 16'h0035, "byte offset");
    done_is(3, M_IX2, 2'h3, 8'h33);
    check(lc[3], 16'h0730, "word offset");
    check(lc[4], 16'h012F, "unsigned offset");
    check(ix[4], 8'h30, "pointer kept");
  endtask

  task automatic t_inherent;
    start();
    load(16'h0100, '{8'hA6, 8'hFF, 8'h4C, 8'h99, 8'h5C, 8'h97});
    run(5);
    done_is(1, M_INH, 2'h1, 8'h00);
    check(cc[1], 5'h0A, "increment flags");
    check(cc[2], 5'h0B, "carry set");
    done_is(3, M_INH, 2'h1, 8'h00);
    check(ix[3], 8'h01, "pointer increment");
    check(cc[3], 5'h09, "pointer flags");
    check(ix[4], 8'h00, "transfer");
  endtask

  // Illegal store-immediate sits mid-stream, then RMW and a jump
  task automatic t_store_rmw_jump;
    start();
    load(16'h0100, '{8'hA6, 8'h77, 8'hB7, 8'h60, 8'hA7, 8'hA6, 8'h11,
                     8'h3C, 8'h61, 8'hCC, 8'h02, 8'h00});
    load(16'h0200, '{8'hA6, 8'h99});
    u_mem.put(16'h0061, 8'h41);
    run(7);
    check(lc[1], 16'h0060, "store location");
    check(u_mem.mem[16'h0060], 8'h77, "stored byte");
    check(il[1], 1'b0, "store legal");
    check(il[2], 1'b1, "immediate store refused");
    done_is(3, M_IMM, 2'h2, 8'h11);
    check(lc[4], 16'h0061, "rmw location");
    check(u_mem.mem[16'h0061], 8'h42, "rmw result");
    check(md[5], M_EXT, "jump mode");
    check(lc[5], 16'h0200, "jump target");
    check(ac[6], 8'h99, "after jump");
  endtask

  initial begin
    rst_b = 1'b0;
    n_fail = 0;
    tests_run = 0;
    nd = 0;
    t_load_modes();
    t_indexed();
    t_inherent();
    t_store_rmw_jump();
    tally_and_finish();
  end
endmodule
